/* File: src/crbt_timer.sv */
// Capture/reload/baud timer with APB register access
//
// Summary of operation
// (RQ1) 16-bit counter of two bytes plus separate 16-bit capture/reload pair.
// (RQ2) Mode from run, serial clock selects and capture/reload select bits.
// (RQ3) Overflow flag set on counter overflow; only software clears it.
// (RQ4) Overflow flag stays unset by overflow while either serial select is 1.
// (RQ5) External flag set on trigger-caused capture or reload when enabled.
// (RQ6) Interrupt requested while enabled and either flag is set.
// (RQ7) Receive select routes this overflow or timer 1 overflow, modes 1/3.
// (RQ8) Transmit select routes this overflow or timer 1 overflow, independently.
// (RQ9) Trigger ignored when disabled; no trigger reload while clocking serial.
// (RQ10) Counter counts while run bit is 1, holds while 0.
// (RQ11) Counter select 0 counts oscillator/12; 1 counts external falling edges.
// (RQ12) Capture mode: free-running 16-bit count, overflow sets flag, no reload.
// (RQ13) Capture mode trigger edge copies count bytes into capture pair.
// (RQ14) Reload mode overflow sets flag and loads counter from the pair.
// (RQ15) Reload mode trigger edge also reloads and sets external flag.
// (RQ16) Serial selects override capture select; overflow always reloads.
// (RQ17) Baud mode rollover reloads; baud rate is overflow rate over 16. The code passes each overflow to the serial clock undivided.
// (RQ18) Baud mode internal clock uses oscillator/2 prescaler.
// (RQ19) Baud mode trigger edge sets external flag only.
// (RQ20) Pins sampled once per machine cycle; high then low is an edge.
// (RQ21) Trigger pin synchronised first; each edge acts exactly once.
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps
`include "crbt_map.svh"

module crbt_timer
    import crbt_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        count_input_pin,
    input  wire logic        external_trigger_pin,
    input  wire logic [1:0]  serial_mode,
    input  wire logic        timer1_overflow,
    output logic             rx_baud_tick,
    output logic             tx_baud_tick,
    output logic             timer_irq
);

    // ************************************************************
    // Declarations
    // ************************************************************
    crbt_ctrl_t  ctrl;
    crbt_mode_t  mode;
    logic [15:0] count;
    logic [15:0] reload;
    logic        irq_enable;
    logic        wr;
    logic        wr_ctrl;
    logic        wr_cnt_lo;
    logic        wr_cnt_hi;
    logic        wr_cap_lo;
    logic        wr_cap_hi;
    logic        wr_cnt;
    logic        wr_cap;
    logic        trig_meta;
    logic        trig_sync;
    logic        cnt_meta;
    logic        cnt_sync;
    logic        trig_samp;
    logic        cnt_samp;
    logic        trig_fall;
    logic        cnt_fall;
    logic [3:0]  mc_cnt;
    logic        mc_tick;
    logic        half_ph;
    logic        count_tick;
    logic        ovf_evt;
    logic        ovf_set;
    logic        trig_evt;
    logic        trig_reload;
    logic        trig_capture;
    logic        reload_on_ovf;
    logic        serial_var;
    logic [31:0] next_prdata;
    logic        next_pslverr;

    // ************************************************************
    // APB slave: no wait states, registered answer
    // ************************************************************
    assign wr        = psel && penable && pready && pwrite;
    assign wr_ctrl   = wr && (paddr == `CRBT_OFS_CTRL);
    assign wr_cnt_lo = wr && (paddr == `CRBT_OFS_COUNT_LO);
    assign wr_cnt_hi = wr && (paddr == `CRBT_OFS_COUNT_HI);
    assign wr_cap_lo = wr && (paddr == `CRBT_OFS_CAP_LO);
    assign wr_cap_hi = wr && (paddr == `CRBT_OFS_CAP_HI);
    assign wr_cnt    = wr_cnt_lo || wr_cnt_hi;
    assign wr_cap    = wr_cap_lo || wr_cap_hi;

    always_comb begin
        next_prdata  = `CRBT_BUS_RST;
        next_pslverr = 1'b0;
        case (paddr)
            `CRBT_OFS_CTRL:     next_prdata[7:0] = ctrl;
            `CRBT_OFS_COUNT_LO: next_prdata[7:0] = count[7:0];
            `CRBT_OFS_COUNT_HI: next_prdata[7:0] = count[15:8];
            `CRBT_OFS_CAP_LO:   next_prdata[7:0] = reload[7:0];
            `CRBT_OFS_CAP_HI:   next_prdata[7:0] = reload[15:8];
            `CRBT_OFS_IEN:      next_prdata[`CRBT_IEN_BIT] = irq_enable;
            default:            next_pslverr = 1'b1;
        endcase
    end

    // Ready rises in the first access cycle and drops after it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= `CRBT_BUS_RST;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            if (psel && !penable) begin
                prdata  <= pwrite ? `CRBT_BUS_RST : next_prdata;
                pslverr <= next_pslverr;
            end
        end
    end

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_meta <= 1'b1;
            trig_sync <= 1'b1;
            cnt_meta  <= 1'b1;
            cnt_sync  <= 1'b1;
        end else begin
            trig_meta <= external_trigger_pin;        // [RQ21]
            trig_sync <= trig_meta;                   // [RQ21]
            cnt_meta  <= count_input_pin;
            cnt_sync  <= cnt_meta;
        end
    end

    // ************************************************************
    // Machine cycle and half-rate prescalers
    // ************************************************************
    assign mc_tick = (mc_cnt == `CRBT_MC_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mc_cnt  <= `CRBT_MC_FIRST;
            half_ph <= 1'b0;
        end else begin
            mc_cnt  <= mc_tick ? `CRBT_MC_FIRST : mc_cnt + `CRBT_MC_STEP;
            half_ph <= !half_ph;
        end
    end

    // ************************************************************
    // Edge detection, one sample per machine cycle
    // ************************************************************
    assign trig_fall = mc_tick && trig_samp && !trig_sync;   // [RQ20]
    assign cnt_fall  = mc_tick && cnt_samp && !cnt_sync;     // [RQ20]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_samp <= 1'b1;
            cnt_samp  <= 1'b1;
        end else if (mc_tick) begin
            trig_samp <= trig_sync;
            cnt_samp  <= cnt_sync;
        end
    end

    // ************************************************************
    // Mode decode and event qualification
    // ************************************************************
    always_comb begin
        if (!ctrl.run_bit) begin
            mode = M_OFF;                                          // [RQ2]
        end else if (ctrl.receive_clock_select ||
                     ctrl.transmit_clock_select) begin
            mode = M_BAUD;                                         // [RQ2]
        end else if (ctrl.capture_reload_select) begin
            mode = M_CAPTURE;                                      // [RQ2]
        end else begin
            mode = M_RELOAD;                                       // [RQ2]
        end
    end

    assign trig_evt = trig_fall && ctrl.external_trigger_enable;   // [RQ9]

    always_comb begin
        reload_on_ovf = 1'b0;
        trig_reload   = 1'b0;
        trig_capture  = 1'b0;
        unique case (mode)
            M_OFF:     reload_on_ovf = 1'b0;
            M_RELOAD: begin
                reload_on_ovf = 1'b1;                              // [RQ14]
                trig_reload   = trig_evt;                          // [RQ15]
            end
            M_CAPTURE: trig_capture  = trig_evt;                   // [RQ13]
            M_BAUD:    reload_on_ovf = 1'b1;             // [RQ16] [RQ17]
        endcase
    end

    // Counter clock: external edges, or oscillator/12 or /2 in baud mode
    always_comb begin
        if (mode == M_OFF) begin
            count_tick = 1'b0;                                     // [RQ10]
        end else if (ctrl.counter_select) begin
            count_tick = cnt_fall;                                 // [RQ11]
        end else if (mode == M_BAUD) begin
            count_tick = half_ph;                                  // [RQ18]
        end else begin
            count_tick = mc_tick;                                  // [RQ11]
        end
    end

    assign ovf_evt = count_tick && (count == `CRBT_COUNT_MAX);
    assign ovf_set = ovf_evt && (mode != M_BAUD);                  // [RQ4]

    // ************************************************************
    // Counter
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= `CRBT_WORD_RST;
        end else if (wr_cnt_lo) begin
            count[7:0] <= pwdata[7:0];
        end else if (wr_cnt_hi) begin
            count[15:8] <= pwdata[7:0];
        end else if (trig_reload) begin
            count <= reload;                                       // [RQ15]
        end else if (count_tick) begin
            if (ovf_evt && reload_on_ovf) begin
                count <= reload;                   // [RQ14] [RQ16] [RQ17]
            end else begin
                count <= count + `CRBT_COUNT_STEP;       // [RQ1] [RQ12]
            end
        end
    end

    // ************************************************************
    // Capture/reload pair
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload <= `CRBT_WORD_RST;
        end else if (wr_cap_lo) begin
            reload[7:0] <= pwdata[7:0];
        end else if (wr_cap_hi) begin
            reload[15:8] <= pwdata[7:0];
        end else if (trig_capture) begin
            reload <= count;                                // [RQ1] [RQ13]
        end
    end

    // ************************************************************
    // Control register; hardware set wins over software write
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `CRBT_CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl <= crbt_ctrl_t'(pwdata[`CRBT_BYTE_MSB:0]);     // [RQ3]
            end
            if (ovf_set) begin
                ctrl.overflow_flag <= 1'b1;                 // [RQ3] [RQ12]
            end
            if (trig_evt && (mode != M_OFF)) begin
                ctrl.external_trigger_flag <= 1'b1;  // [RQ5] [RQ15] [RQ19]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable <= 1'b0;
        end else if (wr && (paddr == `CRBT_OFS_IEN)) begin
            irq_enable <= pwdata[`CRBT_IEN_BIT];
        end
    end

    // ************************************************************
    // Interrupt request and serial clock routing
    // ************************************************************
    assign serial_var = serial_mode[`CRBT_SMODE_VAR_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= irq_enable && (ctrl.overflow_flag ||
                                        ctrl.external_trigger_flag); // [RQ6]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_baud_tick <= 1'b0;
            tx_baud_tick <= 1'b0;
        end else begin
            rx_baud_tick <= serial_var && (ctrl.receive_clock_select ?
                                           ovf_evt : timer1_overflow); // [RQ7]
            tx_baud_tick <= serial_var && (ctrl.transmit_clock_select ?
                                           ovf_evt : timer1_overflow); // [RQ8]
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ovf_sets_flag: assert property ( // [RQ3]
        ovf_evt && (mode != M_BAUD) |=> ctrl.overflow_flag)
        else $error("overflow did not set the overflow flag");
    a_ovf_flag_sticky: assert property ( // [RQ3]
        ctrl.overflow_flag && !wr_ctrl |=> ctrl.overflow_flag)
        else $error("overflow flag cleared without software write");
    a_baud_no_flag: assert property ( // [RQ4]
        (mode == M_BAUD) && !ctrl.overflow_flag && !wr_ctrl
        |=> !ctrl.overflow_flag)
        else $error("overflow flag set in baud mode");
    a_ext_flag_sets: assert property ( // [RQ5]
        trig_evt && (mode != M_OFF) |=> ctrl.external_trigger_flag)
        else $error("trigger edge did not set external flag");
    a_irq_request: assert property ( // [RQ6]
        irq_enable && (ctrl.overflow_flag || ctrl.external_trigger_flag)
        |=> timer_irq)
        else $error("interrupt not requested");
    a_irq_quiet: assert property ( // [RQ6]
        !irq_enable && !(wr && (paddr == `CRBT_OFS_IEN)) ##1 1'b1
        |-> !timer_irq)
        else $error("interrupt requested while disabled");
    a_rx_route: assert property ( // [RQ7]
        serial_var && ctrl.receive_clock_select && ovf_evt |=> rx_baud_tick)
        else $error("receive clock missed timer overflow");
    a_tx_route: assert property ( // [RQ8]
        serial_var && !ctrl.transmit_clock_select
        |=> tx_baud_tick == $past(timer1_overflow))
        else $error("transmit clock not from timer 1");
    a_trig_ignored: assert property ( // [RQ9]
        !ctrl.external_trigger_enable && !wr_ctrl
        |=> !$rose(ctrl.external_trigger_flag))
        else $error("external flag set while trigger disabled");
    a_run_stopped: assert property ( // [RQ10]
        !ctrl.run_bit && !wr_cnt |=> $stable(count))
        else $error("counter moved while stopped");
    a_timer_div12: assert property ( // [RQ11]
        count_tick && !ctrl.counter_select && (mode != M_BAUD)
        |=> !count_tick [*8])
        else $error("internal count faster than oscillator/12");
    a_capture_wrap: assert property ( // [RQ12]
        ovf_evt && (mode == M_CAPTURE) && !wr_cnt |=> count == 16'h0000)
        else $error("capture mode overflow did not wrap to zero");
    a_capture_copy: assert property ( // [RQ13]
        trig_capture && !wr_cap |=> reload == $past(count))
        else $error("capture did not copy counter");
    a_reload_ovf: assert property ( // [RQ14]
        ovf_evt && reload_on_ovf && !wr_cnt |=> count == $past(reload))
        else $error("overflow did not reload counter");
    a_trig_reload: assert property ( // [RQ15]
        trig_reload && !wr_cnt |=> count == $past(reload))
        else $error("trigger did not reload counter");
    a_baud_forced: assert property ( // [RQ16]
        ovf_evt && (mode == M_BAUD) && ctrl.capture_reload_select
        && !wr_cnt |=> count == $past(reload))
        else $error("baud mode did not force reload");
    a_baud_div2: assert property ( // [RQ18]
        count_tick && !ctrl.counter_select && (mode == M_BAUD) && !wr_ctrl
        |=> !count_tick ##1 (count_tick || $past(wr_ctrl)))
        else $error("baud prescaler not oscillator/2");
    a_baud_trig_only: assert property ( // [RQ19]
        trig_evt && (mode == M_BAUD) && !count_tick && !wr_cnt && !wr_cap
        |=> $stable(count) && $stable(reload))
        else $error("trigger altered counter in baud mode");
    a_edge_spacing: assert property ( // [RQ20]
        trig_fall |=> !trig_fall [*8])
        else $error("trigger sampled more than once per cycle");
    a_edge_once: assert property ( // [RQ21]
        trig_fall |=> !trig_samp [*8])
        else $error("single edge acted twice");
    a_apb_ready: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("APB ready not one cycle after setup");
endmodule

/* File: src/crbt_map.svh */
// Register offsets, field positions, reset values and divider counts
`ifndef CRBT_MAP_SVH
`define CRBT_MAP_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define CRBT_OFS_CTRL      12'h0C8
`define CRBT_OFS_COUNT_LO  12'h0CC
`define CRBT_OFS_COUNT_HI  12'h0D0
`define CRBT_OFS_CAP_LO    12'h0D4
`define CRBT_OFS_CAP_HI    12'h0D8
`define CRBT_OFS_IEN       12'h0DC

// ****************************************************************
// Field positions
// ****************************************************************
`define CRBT_IEN_BIT       0
`define CRBT_SMODE_VAR_BIT 0
`define CRBT_BYTE_MSB      7

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define CRBT_CTRL_RST      8'h00
`define CRBT_WORD_RST      16'h0000
`define CRBT_BUS_RST       32'h0000_0000
`define CRBT_COUNT_MAX     16'hFFFF
`define CRBT_COUNT_STEP    16'h0001
`define CRBT_MC_LAST       4'hB
`define CRBT_MC_FIRST      4'h0
`define CRBT_MC_STEP       4'h1

`endif

/* File: src/crbt_pkg.sv */
// Types shared by the capture/reload/baud timer
package crbt_pkg;

    // ************************************************************
    // Control register layout, bit 7 first
    // ************************************************************
    typedef struct packed {
        logic overflow_flag;
        logic external_trigger_flag;
        logic receive_clock_select;
        logic transmit_clock_select;
        logic external_trigger_enable;
        logic run_bit;
        logic counter_select;
        logic capture_reload_select;
    } crbt_ctrl_t;

    // ************************************************************
    // Operating modes
    // ************************************************************
    typedef enum logic [3:0] {
        M_OFF     = 4'b0001,
        M_RELOAD  = 4'b0010,
        M_CAPTURE = 4'b0100,
        M_BAUD    = 4'b1000
    } crbt_mode_t;

endpackage

/* File: testbench/crbt_pins_model.sv */
// Far-side model: trigger and count pins, timer 1 pulses, tick counters
`timescale 1ns/10ps

module crbt_pins_model (
    input  wire logic pclk,
    input  wire logic rx_baud_tick,
    input  wire logic tx_baud_tick,
    output logic      count_input_pin,
    output logic      external_trigger_pin,
    output logic      timer1_overflow
);
    int n_rx = 0;
    int n_tx = 0;
    int n_t1 = 0;
    int div  = 0;

    // ************************************************************
    // Idle levels: both pins pulled high
    // ************************************************************
    initial begin
        count_input_pin      = 1'b1;
        external_trigger_pin = 1'b1;
        timer1_overflow      = 1'b0;
    end

    // ************************************************************
    // Timer 1 pulse every tenth cycle; serial clock counters
    // ************************************************************
    always @(posedge pclk) begin
        div             <= (div == 9) ? 0 : div + 1;
        timer1_overflow <= (div == 9);
        if (timer1_overflow === 1'b1)
            n_t1 <= n_t1 + 1;
        if (rx_baud_tick === 1'b1)
            n_rx <= n_rx + 1;
        if (tx_baud_tick === 1'b1)
            n_tx <= n_tx + 1;
    end

    // One falling edge; each level held well past a machine cycle
    task automatic pulse(input bit trig);
        @(posedge pclk);
        external_trigger_pin <= !trig;
        count_input_pin      <= trig;
        repeat (30) @(posedge pclk);
        external_trigger_pin <= 1'b1;
        count_input_pin      <= 1'b1;
        repeat (30) @(posedge pclk);
    endtask
endmodule

/* File: testbench/crbt_timer_tb.sv */
// Self-checking bench for the capture/reload/baud timer
`timescale 1ns/10ps
`include "crbt_map.svh"

module crbt_timer_tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rdat;
    logic        pready;
    logic        pslverr;
    logic        perr;
    logic        cpin;
    logic        tpin;
    logic        t1ov;
    logic        rxt;
    logic        txt;
    logic        irq;
    logic [1:0]  serial_mode;
    int          n_mismatch;
    int          cmp_count;
    int          i;

    crbt_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .count_input_pin(cpin),
        .external_trigger_pin(tpin), .serial_mode(serial_mode),
        .timer1_overflow(t1ov), .rx_baud_tick(rxt), .tx_baud_tick(txt),
        .timer_irq(irq));

    crbt_pins_model pins (.pclk(pclk), .rx_baud_tick(rxt),
        .tx_baud_tick(txt), .count_input_pin(cpin),
        .external_trigger_pin(tpin), .timer1_overflow(t1ov));

    // ************************************************************
    // Verdict, compare and bus tasks
    // ************************************************************
    task close_out();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_mismatch++;
            close_out();
        end
        rdat = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d});
    endtask

    task rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h00000000);
        chk(rdat, {24'h000000, e});
    endtask

    // Serial clock pulses seen over 400 cycles, within one of expected
    task tick_win(input int etx, input int erx);
        int s_tx;
        int s_rx;
        s_tx = pins.n_tx;
        s_rx = pins.n_rx;
        repeat (400) @(posedge pclk);
        chk({31'h0, (pins.n_tx - s_tx) inside {[etx-1:etx+1]}}, 32'h1);
        chk({31'h0, (pins.n_rx - s_rx) inside {[erx-1:erx+1]}}, 32'h1);
    endtask

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 12'h000;
        pwdata      = 32'h00000000;
        serial_mode = 2'b00;
        n_mismatch  = 0;
        cmp_count   = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 6; i++)
            rd(12'h0C8 + 12'(4 * i), 8'h00);
        apb(1'b0, 12'h0E0, 32'h00000000);
        chk({31'h0, perr}, 32'h1);
        wr(`CRBT_OFS_CAP_LO, 8'h34);
        wr(`CRBT_OFS_CAP_HI, 8'h12);
        wr(`CRBT_OFS_COUNT_LO, 8'hFE);
        wr(`CRBT_OFS_COUNT_HI, 8'hFF);
        wr(`CRBT_OFS_IEN, 8'h01);
        wr(`CRBT_OFS_CTRL, 8'h04);
        for (i = 0; i < 200 && irq !== 1'b1; i++)
            @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        rd(`CRBT_OFS_CTRL, 8'h84);
        rd(`CRBT_OFS_COUNT_HI, 8'h12);
        wr(`CRBT_OFS_CTRL, 8'h00);
        rd(`CRBT_OFS_CTRL, 8'h00);
        chk({31'h0, irq}, 32'h0);
        wr(`CRBT_OFS_COUNT_LO, 8'h00);
        wr(`CRBT_OFS_COUNT_HI, 8'h56);
        wr(`CRBT_OFS_CTRL, 8'h0D);
        pins.pulse(1'b1);
        rd(`CRBT_OFS_CAP_HI, 8'h56);
        rd(`CRBT_OFS_CTRL, 8'h4D);
        wr(`CRBT_OFS_CTRL, 8'h05);
        wr(`CRBT_OFS_COUNT_HI, 8'h77);
        pins.pulse(1'b1);
        rd(`CRBT_OFS_CAP_HI, 8'h56);
        rd(`CRBT_OFS_CTRL, 8'h05);
        wr(`CRBT_OFS_CTRL, 8'h0C);
        wr(`CRBT_OFS_COUNT_HI, 8'h99);
        pins.pulse(1'b1);
        rd(`CRBT_OFS_COUNT_HI, 8'h56);
        rd(`CRBT_OFS_CTRL, 8'h4C);
        wr(`CRBT_OFS_CTRL, 8'h00);
        wr(`CRBT_OFS_COUNT_LO, 8'h00);
        wr(`CRBT_OFS_COUNT_HI, 8'h00);
        wr(`CRBT_OFS_CTRL, 8'h06);
        repeat (3) pins.pulse(1'b0);
        rd(`CRBT_OFS_COUNT_LO, 8'h03);
        wr(`CRBT_OFS_CTRL, 8'h02);
        pins.pulse(1'b0);
        rd(`CRBT_OFS_COUNT_LO, 8'h03);
        wr(`CRBT_OFS_CAP_LO, 8'hFE);
        wr(`CRBT_OFS_CAP_HI, 8'hFF);
        wr(`CRBT_OFS_COUNT_LO, 8'hFE);
        wr(`CRBT_OFS_COUNT_HI, 8'hFF);
        serial_mode <= 2'b01;
        wr(`CRBT_OFS_CTRL, 8'h14);
        tick_win(100, 40);
        rd(`CRBT_OFS_CTRL, 8'h14);
        wr(`CRBT_OFS_CTRL, 8'h24);
        tick_win(40, 100);
        wr(`CRBT_OFS_CTRL, 8'h1C);
        pins.pulse(1'b1);
        rd(`CRBT_OFS_CTRL, 8'h5C);
        serial_mode <= 2'b00;
        tick_win(0, 0);
        close_out();
    end
endmodule
